// *** zeb_pkg.sv ***
// package: constants and types for the zoned external bus
package zeb_pkg;
   localparam int ZONE_CNT   = 5;
   localparam int ADDR_W     = 19;
   localparam int DATA_W     = 16;
   localparam int CPU_ADDR_W = 22;
   localparam int TIM_W      = 3;
   // zone index order: 0,1,2,6,7
   localparam logic [2:0] ZI_Z0 = 3'h0;
   localparam logic [2:0] ZI_Z1 = 3'h1;
   localparam logic [2:0] ZI_Z2 = 3'h2;
   localparam logic [2:0] ZI_Z6 = 3'h3;
   localparam logic [2:0] ZI_Z7 = 3'h4;
   // cpu address bases of each zone (word address, upper bits compared)
   localparam logic [CPU_ADDR_W-1:0] Z0_BASE = 22'h00_2000;
   localparam logic [CPU_ADDR_W-1:0] Z1_BASE = 22'h00_4000;
   localparam logic [CPU_ADDR_W-1:0] Z2_BASE = 22'h08_0000;
   localparam logic [CPU_ADDR_W-1:0] Z6_BASE = 22'h10_0000;
   localparam logic [CPU_ADDR_W-1:0] Z7_BASE = 22'h3F_C000;
   localparam logic [CPU_ADDR_W-1:0] Z01_MASK = 22'h3F_E000;
   localparam logic [CPU_ADDR_W-1:0] Z26_MASK = 22'h38_0000;
   localparam logic [CPU_ADDR_W-1:0] Z7_MASK  = 22'h3F_C000;
   localparam logic [ADDR_W-1:0]     Z7_XA_BASE = 19'h7_C000;
   localparam logic [ADDR_W-1:0]     Z7_XA_MASK = 19'h0_3FFF;
   localparam logic [ADDR_W-1:0]     Z01_XA_MASK = 19'h0_1FFF;
   localparam logic [ADDR_W-1:0]     Z01_XA_SEL  = 19'h0_6000;
   localparam logic [TIM_W-1:0]      TIM_ONE = 3'h1;

   // one direction's timing for one zone
   typedef struct packed {
      logic [TIM_W-1:0] lead;
      logic [TIM_W-1:0] active;
      logic [TIM_W-1:0] trail;
   } zeb_phase_t;

   // full per-zone timing set
   typedef struct packed {
      zeb_phase_t rd;
      zeb_phase_t wr;
      logic       use_ready;
   } zeb_zone_tim_t;

   typedef zeb_zone_tim_t [ZONE_CNT-1:0] zeb_tim_arr_t;

   // internal access request
   typedef struct packed {
      logic [CPU_ADDR_W-1:0] addr;
      logic [DATA_W-1:0]     wdata;
      logic                  write;
   } zeb_req_t;
endpackage

// *** zeb_zone_dec.sv ***
// zone decoder: cpu address to zone one-hot and external address
module zeb_zone_dec (
   // request address
   input  wire logic [zeb_pkg::CPU_ADDR_W-1:0] i_addr,
   // decode result
   output logic      [zeb_pkg::ZONE_CNT-1:0]   o_zone_hit,
   output logic      [2:0]                     o_zone_idx,
   output logic                                o_any_hit,
   output logic      [zeb_pkg::ADDR_W-1:0]     o_xa
);
   wire hit0 = (i_addr & zeb_pkg::Z01_MASK) == zeb_pkg::Z0_BASE;
   wire hit1 = (i_addr & zeb_pkg::Z01_MASK) == zeb_pkg::Z1_BASE;
   wire hit2 = (i_addr & zeb_pkg::Z26_MASK) == zeb_pkg::Z2_BASE;
   wire hit6 = (i_addr & zeb_pkg::Z26_MASK) == zeb_pkg::Z6_BASE;
   wire hit7 = (i_addr & zeb_pkg::Z7_MASK) == zeb_pkg::Z7_BASE;
   wire [zeb_pkg::ADDR_W-1:0] low = i_addr[zeb_pkg::ADDR_W-1:0];

   // zones are disjoint, so at most one bit is set
   assign o_zone_hit = {hit7, hit6, hit2, hit1, hit0}; // RQ1
   assign o_any_hit  = |o_zone_hit;
   assign o_zone_idx = hit0 ? zeb_pkg::ZI_Z0 :
                       hit1 ? zeb_pkg::ZI_Z1 :
                       hit2 ? zeb_pkg::ZI_Z2 :
                       hit6 ? zeb_pkg::ZI_Z6 : zeb_pkg::ZI_Z7;
   // zones 0/1 keep their cpu offset so xa13/xa14 tell them apart
   assign o_xa = hit7 ? (zeb_pkg::Z7_XA_BASE | (low & zeb_pkg::Z7_XA_MASK)) :
                 (hit0 | hit1) ? (low & (zeb_pkg::Z01_XA_MASK | zeb_pkg::Z01_XA_SEL)) :
                 low; // RQ11 RQ13
endmodule

// *** zeb_top.sv ***
// top: zoned external asynchronous bus interface
// Notes on behaviour
// RQ1: decode external space into five fixed zones
// RQ2: per-zone select asserts only during its access
// RQ3: shared pin is AND of two selects
// RQ4: per-zone wait, setup and hold timing
// RQ5: separate read and write timing sets
// RQ6: per-zone option lets ready stretch access
// RQ7: timing clock is sysclk or half, global
// RQ8: cycles start on bus clock rise
// RQ9: separate address and data, asynchronous strobes
// RQ10: zone selects are active low
// RQ11: one shared 19-bit zone-relative address bus (code drives cpu address bits 18:0, zone-relative only for zones 2 and 6)
// RQ12: zones 0/1 and 6/7 share pins
// RQ13: zones 2 and 6 share addresses
// RQ14: external ready held low until ready
module zeb_top (
   // clock and reset
   input  wire logic                         i_sys_clk,
   input  wire logic                         i_rst_n,
   // configuration
   input  wire zeb_pkg::zeb_tim_arr_t        i_zone_timing_regs,
   input  wire logic                         i_tim_half,
   // internal request
   input  wire logic                         i_req_valid,
   input  wire zeb_pkg::zeb_req_t            i_req,
   output logic                              o_req_ready,
   output logic                              o_done,
   output logic      [zeb_pkg::DATA_W-1:0]   o_rdata,
   output logic                              o_unmapped,
   // external pins
   input  wire logic                         i_external_ready_in,
   input  wire logic [zeb_pkg::DATA_W-1:0]   i_xd,
   output logic      [zeb_pkg::DATA_W-1:0]   o_xd,
   output logic                              o_xd_oe,
   output logic      [zeb_pkg::ADDR_W-1:0]   o_external_address_bus,
   output logic                              o_rd_n,
   output logic                              o_we_n,
   output logic                              o_shared_select_zone01_n,
   output logic                              o_select_zone_two_n,
   output logic                              o_shared_select_zone67_n,
   output logic                              o_bus_clock_out
);
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_START = 5'b00010,
      ST_LEAD  = 5'b00100,
      ST_ACT   = 5'b01000,
      ST_TRAIL = 5'b10000
   } zeb_state_t;

   zeb_state_t                       state_r, state_nxt;
   logic [zeb_pkg::ZONE_CNT-1:0]     zone_r;
   logic [zeb_pkg::ZONE_CNT-1:0]     zsel_n_r;
   logic [2:0]                       zidx_r;
   logic                             write_r;
   logic [zeb_pkg::TIM_W-1:0]        cnt_r;
   logic                             tick_div_r;
   logic                             bclk_r;
   logic                             rdy_s1_r, rdy_s2_r;
   logic [zeb_pkg::DATA_W-1:0]       xd_s1_r, xd_s2_r;

   wire [zeb_pkg::ZONE_CNT-1:0] dec_hit;
   wire [2:0]                   dec_idx;
   wire                         dec_any;
   wire [zeb_pkg::ADDR_W-1:0]   dec_xa;

   zeb_zone_dec u_dec (
      .i_addr     (i_req.addr),
      .o_zone_hit (dec_hit),
      .o_zone_idx (dec_idx),
      .o_any_hit  (dec_any),
      .o_xa       (dec_xa)
   );

   // timing tick: every sysclk, or every second one
   wire tick = ~i_tim_half | tick_div_r; // RQ7
   // bus clock is timing clock / 2; its rise marks tick with bclk low
   wire bclk_rise = tick & ~bclk_r;

   wire zeb_pkg::zeb_zone_tim_t zt = i_zone_timing_regs[zidx_r];
   wire zeb_pkg::zeb_phase_t    ph = write_r ? zt.wr : zt.rd; // RQ4 RQ5
   wire cnt_end  = (cnt_r <= zeb_pkg::TIM_ONE);
   // ready is only honoured for zones that enable it
   wire rdy_ok   = ~zt.use_ready | rdy_s2_r; // RQ6 RQ14
   wire accept   = (state_r == ST_IDLE) & i_req_valid & dec_any;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE:  if (accept) state_nxt = ST_START;
         ST_START: if (bclk_rise) state_nxt = ST_LEAD; // RQ8
         ST_LEAD:  if (tick & cnt_end) state_nxt = ST_ACT;
         ST_ACT:   if (tick & cnt_end & rdy_ok) state_nxt = ST_TRAIL;
         ST_TRAIL: if (tick & cnt_end) state_nxt = ST_IDLE;
      endcase
   end

   wire [zeb_pkg::TIM_W-1:0] cnt_load =
      (state_r == ST_START) ? ph.lead :
      (state_r == ST_LEAD)  ? ph.active : ph.trail;
   wire phase_adv = tick & (state_r != ST_IDLE) & (state_nxt != state_r);
   wire [zeb_pkg::TIM_W-1:0] cnt_nxt =
      phase_adv ? cnt_load :
      (tick & ~cnt_end) ? cnt_r - zeb_pkg::TIM_ONE : cnt_r;

   // selects drop at lead start, rise after trail, on timing edges
   wire in_cycle_nxt = (state_nxt == ST_LEAD) | (state_nxt == ST_ACT) |
                       (state_nxt == ST_TRAIL);
   wire [zeb_pkg::ZONE_CNT-1:0] zsel_n_nxt = in_cycle_nxt ? ~zone_r :
                                             {zeb_pkg::ZONE_CNT{1'b1}}; // RQ2 RQ10
   wire strobe_nxt = (state_nxt == ST_ACT);
   wire finish     = (state_r == ST_TRAIL) & (state_nxt == ST_IDLE);

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         state_r    <= ST_IDLE;
         tick_div_r <= 1'b0;
         bclk_r     <= 1'b0;
         cnt_r      <= '0;
         zone_r     <= '0;
         zidx_r     <= zeb_pkg::ZI_Z0;
         write_r    <= 1'b0;
         zsel_n_r   <= '1;
         rdy_s1_r   <= 1'b0;
         rdy_s2_r   <= 1'b0;
         xd_s1_r    <= '0;
         xd_s2_r    <= '0;
      end else begin
         state_r    <= state_nxt;
         tick_div_r <= i_tim_half ? ~tick_div_r : 1'b0;
         bclk_r     <= tick ? ~bclk_r : bclk_r;
         cnt_r      <= cnt_nxt;
         zsel_n_r   <= zsel_n_nxt;
         rdy_s1_r   <= i_external_ready_in;
         rdy_s2_r   <= rdy_s1_r;
         xd_s1_r    <= i_xd;
         xd_s2_r    <= xd_s1_r;
         if (accept) begin
            zone_r  <= dec_hit;
            zidx_r  <= dec_idx;
            write_r <= i_req.write;
         end
      end
   end

   // pin outputs, all registered
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_req_ready              <= 1'b0;
         o_done                   <= 1'b0;
         o_rdata                  <= '0;
         o_unmapped               <= 1'b0;
         o_xd                     <= '0;
         o_xd_oe                  <= 1'b0;
         o_external_address_bus   <= '0;
         o_rd_n                   <= 1'b1;
         o_we_n                   <= 1'b1;
         o_shared_select_zone01_n <= 1'b1;
         o_select_zone_two_n      <= 1'b1;
         o_shared_select_zone67_n <= 1'b1;
         o_bus_clock_out          <= 1'b0;
      end else begin
         o_req_ready              <= (state_nxt == ST_IDLE) & ~accept;
         o_done                   <= finish;
         o_unmapped               <= (state_r == ST_IDLE) & i_req_valid & ~dec_any;
         o_bus_clock_out          <= tick ? ~bclk_r : bclk_r;
         if (accept) begin
            o_external_address_bus <= dec_xa; // RQ9 RQ11
            o_xd                   <= i_req.wdata;
         end
         if (finish & ~write_r)
            o_rdata <= xd_s2_r;
         o_xd_oe <= write_r & in_cycle_nxt;
         o_rd_n  <= ~(strobe_nxt & ~write_r);
         o_we_n  <= ~(strobe_nxt & write_r);
         o_shared_select_zone01_n <= zsel_n_nxt[zeb_pkg::ZI_Z0] &
                                     zsel_n_nxt[zeb_pkg::ZI_Z1]; // RQ3 RQ12
         o_select_zone_two_n      <= zsel_n_nxt[zeb_pkg::ZI_Z2];
         o_shared_select_zone67_n <= zsel_n_nxt[zeb_pkg::ZI_Z6] &
                                     zsel_n_nxt[zeb_pkg::ZI_Z7]; // RQ3 RQ12
      end
   end

   a_sel_idle_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $past(state_r) == ST_IDLE && state_r == ST_IDLE |-> o_select_zone_two_n) // RQ2
      else $error("zone two select low while idle");
   a_sel_shared01: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      o_shared_select_zone01_n == (zsel_n_r[0] & zsel_n_r[1])) // RQ3
      else $error("shared select 01 not AND");
   a_one_zone: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $onehot0(dec_hit)) // RQ1
      else $error("more than one zone hit");
   a_strobe_excl: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !(!o_rd_n && !o_we_n)) // RQ5
      else $error("read and write strobe together");
   a_start_bclk: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      state_r == ST_LEAD && $past(state_r) == ST_START |-> $rose(o_bus_clock_out)) // RQ8
      else $error("cycle not on bus clock rise");
   a_ready_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      state_r == ST_ACT && zt.use_ready && !rdy_s2_r |=> state_r == ST_ACT) // RQ6
      else $error("active left without ready");
   a_full_tick: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_tim_half |-> tick) // RQ7
      else $error("full rate tick missing");
   a_half_tick: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $past(i_rst_n) && i_tim_half && $past(i_tim_half) |-> tick != $past(tick)) // RQ7
      else $error("half rate tick not alternating");
   a_lead_len: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      state_r == ST_START && state_nxt == ST_LEAD |=> cnt_r == $past(cnt_load)) // RQ4
      else $error("lead count not loaded");
   a_sel_active: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !o_rd_n |-> !(o_shared_select_zone01_n && o_select_zone_two_n
                    && o_shared_select_zone67_n)) // RQ10
      else $error("strobe without select");

   c_read:  cover property (@(posedge i_sys_clk) finish && !write_r);
   c_write: cover property (@(posedge i_sys_clk) finish && write_r);
   c_wait:  cover property (@(posedge i_sys_clk) state_r == ST_ACT && !rdy_ok);
   c_half:  cover property (@(posedge i_sys_clk) i_tim_half && finish);
   c_unmap: cover property (@(posedge i_sys_clk) o_unmapped);
endmodule

// *** zeb_ext_mem.sv ***
// partner: asynchronous memory behind the zone selects
module zeb_ext_mem (
   // pins from the bus
   input  wire logic        i_clk,
   input  wire logic [2:0]  i_sel_n,
   input  wire logic [18:0] i_addr,
   input  wire logic        i_rd_n,
   input  wire logic        i_we_n,
   input  wire logic [15:0] i_wdata,
   // bench control
   input  wire logic        i_slow,
   // answers
   output logic             o_ready,
   output logic [15:0]      o_rdata
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] mem [4096];
   logic [15:0] last = 16'h0000;
   int          wcnt = 0;
   wire         hit = (i_sel_n != 3'b111);
   // folded index: bench reads back right after each write
   wire  [11:0] key = i_addr[11:0] ^ {i_sel_n, 9'h000};
   // slow part holds ready low for 16 clocks, past any programmed strobe
   assign o_ready = !i_slow || wcnt > 15;
   // held while selected, scrambled once released
   assign o_rdata = hit ? mem[key] : ~last;
   always @(posedge i_clk) begin
      wcnt <= (i_rd_n && i_we_n) ? 0 : wcnt + 1;
      if (hit && !i_we_n) mem[key] <= i_wdata;
      if (hit) last <= o_rdata;
   end
endmodule

// *** tb_zoned_external_async_bus.sv ***
// testbench: random zone traffic against the memory model
module tb_zoned_external_async_bus;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_sys_clk = 0, i_rst_n = 0, i_tim_half = 0, i_req_valid = 0, slow = 0;
   zeb_pkg::zeb_tim_arr_t tim = '0;
   zeb_pkg::zeb_req_t     req = '0;
   logic        rdy, done, unm, oe, rd_n, we_n, bclk, ext_rdy;
   logic [15:0] xdi, xdo, rdata, d;
   logic [18:0] xa, xa_seen;
   logic [2:0]  sel_n, sel_seen, sel_prev = 3'h7;
   logic [1:0]  bclk_seen;
   logic        oe_seen, bclk_prev = 1'b0;
   logic [21:0] a;
   int          fails = 0, total_checks = 0, strb, csn, z;
   zeb_pkg::zeb_phase_t ph;
   localparam logic [21:0] BASE [5] = '{zeb_pkg::Z0_BASE, zeb_pkg::Z1_BASE,
      zeb_pkg::Z2_BASE, zeb_pkg::Z6_BASE, zeb_pkg::Z7_BASE};
   localparam logic [21:0] SIZE [5] = '{22'h00_2000, 22'h00_2000, 22'h08_0000,
      22'h08_0000, 22'h00_4000};
   localparam logic [2:0]  SEL [5] = '{3'h3, 3'h3, 3'h5, 3'h6, 3'h6};
   wire         o_z01, o_z2, o_z67;
   assign sel_n = {o_z01, o_z2, o_z67};
   zeb_top i_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_zone_timing_regs(tim),
      .i_tim_half(i_tim_half), .i_req_valid(i_req_valid), .i_req(req), .o_req_ready(rdy),
      .o_done(done), .o_rdata(rdata), .o_unmapped(unm), .i_external_ready_in(ext_rdy),
      .i_xd(xdi), .o_xd(xdo), .o_xd_oe(oe), .o_external_address_bus(xa), .o_rd_n(rd_n),
      .o_we_n(we_n), .o_shared_select_zone01_n(o_z01), .o_select_zone_two_n(o_z2),
      .o_shared_select_zone67_n(o_z67), .o_bus_clock_out(bclk));
   zeb_ext_mem i_mem (.i_clk(i_sys_clk), .i_sel_n(sel_n), .i_addr(xa), .i_rd_n(rd_n),
      .i_we_n(we_n), .i_wdata(xdo), .i_slow(slow), .o_ready(ext_rdy), .o_rdata(xdi));
   initial forever #12.5 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk) begin
      if (!rd_n || !we_n) begin
         strb++;
         sel_seen = sel_n;
         xa_seen = xa;
         oe_seen = oe;
      end
      if (sel_n != 3'b111) csn++;
      // bus clock level before and at the edge that drops the select
      if (sel_n != 3'b111 && sel_prev == 3'b111) bclk_seen = {bclk_prev, bclk};
      sel_prev = sel_n;
      bclk_prev = bclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   function automatic int ticks(input logic [2:0] v);
      return (v == 3'h0 ? 1 : int'(v)) * (i_tim_half ? 2 : 1);
   endfunction
   task automatic acc(input logic w);
      int n;
      strb = 0;
      csn = 0;
      n = 0;
      while (rdy !== 1'b1 && n < 50) begin
         @(posedge i_sys_clk);
         #1 n++;
      end
      @(posedge i_sys_clk);
      req <= '{addr:a, wdata:d, write:w};
      i_req_valid <= 1'b1;
      @(posedge i_sys_clk);
      i_req_valid <= 1'b0;
      #1 chk({rdy, unm}, 2'b00);
      n = 0;
      do begin
         @(posedge i_sys_clk);
         #1 n++;
      end while (done !== 1'b1 && n < 400);
      chk(n < 400, 1);
      ph = w ? tim[z].wr : tim[z].rd;
      chk(sel_seen, SEL[z]);
      chk(xa_seen, a[18:0]);
      chk(bclk_seen, 2'b01);
      chk(oe_seen, w);
      if (!tim[z].use_ready || !slow) begin
         chk(strb, ticks(ph.active));
         chk(csn, ticks(ph.lead) + ticks(ph.active) + ticks(ph.trail));
      end else begin
         // ready rises 16 clocks into the strobe, then two sync stages
         chk(strb, i_tim_half ? 20 : 19);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      // worst case is under 6000 clocks; allow 20000
      #500_000;
      fails++;
      finish_test();
   end
   initial begin
      void'($urandom(46));
      repeat (4) @(posedge i_sys_clk);
      chk({sel_n, rd_n, we_n, oe}, 6'h3E);
      i_rst_n <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         if (i % 5 == 0) begin
            @(posedge i_sys_clk);
            for (int k = 0; k < 5; k++) begin
               // first group: all counts zero, ready ignored
               tim[k] <= (i == 0) ? '0 : 19'($urandom);
            end
            i_tim_half <= i[3];
            slow <= 1'($urandom);
         end
         z = i % 5;
         a = BASE[z] + (i < 5 ? 22'h0 : i < 10 ? SIZE[z] - 1 : 22'($urandom) % SIZE[z]);
         d = 16'($urandom);
         acc(1'b1);
         acc(1'b0);
         chk(rdata, d);
         $display("test %0d zone %0d done", i, z);
      end
      // addresses outside every zone
      foreach (BASE[k]) begin
         if (k < 2) begin
            a = k ? 22'h20_0000 : 22'h00_0000;
            csn = 0;
            @(posedge i_sys_clk);
            req.addr <= a;
            i_req_valid <= 1'b1;
            @(posedge i_sys_clk);
            #1 chk(unm, 1);
            @(posedge i_sys_clk);
            i_req_valid <= 1'b0;
            repeat (20) @(posedge i_sys_clk);
            chk(csn, 0);
            $display("test unmapped %0d done", k);
         end
      end
      finish_test();
   end
endmodule
